// ---- hw/dcc_pkg.sv ----
// Shared constants and types for the four-channel DMA channel control block
package dcc_pkg;

	// Channel count and register decode window
	localparam int N_CH     = 4;
	localparam int DEC_BITS = 12;   // Index bits compared against paddr[13:2]
	localparam int N_IRQ    = 64;   // One request line per six-bit source code

	// Register indices; byte address on APB is four times the index
	localparam logic [31:0] IDX_ADC [N_CH] = '{32'hfffff0d0, 32'hfffff0d2,
		32'hfffff0d4, 32'hfffff0d6};
	localparam logic [31:0] IDX_CHC [N_CH] = '{32'hfffff0e0, 32'hfffff0e2,
		32'hfffff0e4, 32'hfffff0e6};
	localparam logic [31:0] IDX_TRG [N_CH] = '{32'h0ffff810, 32'h0ffff812,
		32'h0ffff814, 32'h0ffff816};
	localparam logic [31:0] IDX_STS  = 32'hfffff0f0;  // Channel state summary
	localparam logic [31:0] IDX_PCLR = 32'hfffff0f2;  // Pending flag bit clear

	// Addressing control field positions
	localparam int ADC_SIZE    = 14;
	localparam int ADC_SRC_HI  = 7;
	localparam int ADC_SRC_LO  = 6;
	localparam int ADC_DST_HI  = 5;
	localparam int ADC_DST_LO  = 4;
	localparam int ADC_MODE_HI = 3;
	localparam int ADC_MODE_LO = 2;

	// Channel control field positions
	localparam int CHC_TC   = 7;
	localparam int CHC_KEEP = 3;
	localparam int CHC_INIT = 2;
	localparam int CHC_STG  = 1;
	localparam int CHC_EN   = 0;

	// Trigger factor field positions
	localparam int TRG_PEND   = 7;
	localparam int TRG_SRC_HI = 5;
	localparam int TRG_SRC_LO = 0;

	// Reset values
	localparam logic [15:0] ADC_RST = 16'h0000;
	localparam logic [7:0]  CHC_RST = 8'h00;
	localparam logic [7:0]  TRG_RST = 8'h00;

	// Completion flag delays, in system clocks
	localparam int          TC_DLY_RAM_CLK = 4;
	localparam int          TC_DLY_PIO_CLK = 1;
	localparam logic [2:0]  TC_DLY_RAM_CYC = 3'(TC_DLY_RAM_CLK * 1);
	localparam logic [2:0]  TC_DLY_PIO_CYC = 3'(TC_DLY_PIO_CLK * 1);

	// Decoded address stepping, transfer mode and channel state
	typedef enum logic [1:0] {STEP_INC, STEP_DEC, STEP_FIX, STEP_BAD} dcc_step_t;
	typedef enum logic [1:0] {MODE_SINGLE, MODE_SSTEP, MODE_BAD, MODE_BLOCK} dcc_mode_t;
	typedef enum logic [1:0] {ST_ABORTED, ST_IN_PROGRESS, ST_ENDED} dcc_ch_state_t;

	// Raw addressing control fields as stored
	typedef struct packed {
		logic       size;
		logic [1:0] src;
		logic [1:0] dst;
		logic [1:0] mode;
	} dcc_adc_t;

	// Decoded configuration handed to the transfer engine
	typedef struct packed {
		logic      halfword;
		dcc_step_t src;
		dcc_step_t dst;
		dcc_mode_t mode;
	} dcc_cfg_t;

	// APB request and response bundles
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
		logic [3:0]  pstrb;
	} dcc_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} dcc_apb_rsp_t;

	// Stepping code to direction; the forbidden code is flagged, not obeyed
	function automatic dcc_step_t step_of(input logic [1:0] code);
		case (code)
			2'b00:   return STEP_INC;
			2'b01:   return STEP_DEC;
			2'b10:   return STEP_FIX;
			default: return STEP_BAD;
		endcase
	endfunction

	// Channel state from completion flag and enable
	function automatic dcc_ch_state_t state_of(input logic tc, input logic en);
		if (tc)
			return ST_ENDED;
		else if (en)
			return ST_IN_PROGRESS;
		else
			return ST_ABORTED;
	endfunction

endpackage

// ---- hw/dcc_prio_arb.sv ----
`timescale 1ns/10ps
`default_nettype none
// Fixed-priority start arbiter, lowest channel index wins
module dcc_prio_arb (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic [dcc_pkg::N_CH-1:0] req,
	input  wire logic                     busy,
	output logic      [dcc_pkg::N_CH-1:0] grant
);
	import dcc_pkg::*;

	typedef struct packed {
		logic [N_CH-1:0] grant;   // One-hot start pulse
	} dcc_arb_state_t;

	dcc_arb_state_t s_q;   // Registered state
	dcc_arb_state_t s_d;   // Next state

	// Pick one channel only while the engine is idle and no grant is in flight
	always_comb begin
		s_d = s_q;
		s_d.grant = '0;
		if (!busy && s_q.grant == '0) begin
			for (int i = N_CH - 1; i >= 0; i--) begin
				if (req[i]) begin
					s_d.grant = N_CH'(1) << i;
				end
			end
		end
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign grant = s_q.grant;

endmodule
`default_nettype wire

// ---- hw/dcc_channel_ctrl.sv ----
// What this block does
// - Size bit picks byte or halfword units
// - Source step: increment, decrement, fixed, forbidden
// - Destination step: increment, decrement, fixed, forbidden
// - Mode: single, single-step, block; 10 forbidden
// - Completion flag set at end, cleared by read
// - RAM source delays completion flag four clocks
// - Keep-enabled holds enable; hardware start still accepted
// - Keep-enabled software start needs completion flag read
// - Without keep-enabled, enable clears at end
// - Force-terminate aborts active channel, clears enable
// - Software trigger starts only when enabled, unfinished
// - Terminate and trigger bits read as zero
// - Enable clears before completion flag sets
// - Abort in last cycle with keep completes normally
// - Hardware restart leaves completion flag set
// - Report in progress, aborted or ended state
// - Six-bit source field selects peripheral request
// - Pending flag bit access; source field byte only
// - Requests during standby wait until it ends
// - Pending flag shows request; a grant or software clears it
// - Fixed priority, channel 0 highest
`timescale 1ns/10ps
`default_nettype none
module dcc_channel_ctrl (
	input  wire logic                          clk,
	input  wire logic                          rst,
	input  wire dcc_pkg::dcc_apb_req_t         apb_req,
	output dcc_pkg::dcc_apb_rsp_t              apb_rsp,
	input  wire logic [dcc_pkg::N_IRQ-1:0]     irq_req,
	input  wire logic                          standby,
	input  wire logic                          eng_busy,
	input  wire logic [dcc_pkg::N_CH-1:0]      eng_done,
	input  wire logic [dcc_pkg::N_CH-1:0]      eng_last_cycle,
	input  wire logic [dcc_pkg::N_CH-1:0]      eng_src_ram,
	output logic      [dcc_pkg::N_CH-1:0]      xfer_start,
	output logic      [dcc_pkg::N_CH-1:0]      xfer_abort,
	output dcc_pkg::dcc_cfg_t [dcc_pkg::N_CH-1:0]      ch_cfg,
	output dcc_pkg::dcc_ch_state_t [dcc_pkg::N_CH-1:0] ch_state
);
	import dcc_pkg::*;

	// Per-channel control and status
	typedef struct packed {
		logic       en;       // Transfer enable
		logic       keep;     // Keep enable across terminal count
		logic       tc;       // Completion flag
		logic       pend;     // Peripheral request pending
		logic       sw_req;   // Accepted software start awaiting grant
		logic       active;   // Granted and not yet finished
		logic       tc_wait;  // Completion flag countdown running
		logic [2:0] tc_cnt;   // Clocks left before the flag sets
		logic [5:0] trig;     // Peripheral request source code
		dcc_adc_t   adc;      // Addressing control fields
	} dcc_ch_t;

	// Whole module state
	typedef struct packed {
		dcc_ch_t [N_CH-1:0] ch;
		logic [N_CH-1:0]    abort;   // One-cycle abort pulse to engine
		logic [31:0]        rdata;   // Read data captured in setup phase
	} dcc_state_t;

	dcc_state_t      s_q;       // Registered state
	dcc_state_t      s_d;       // Next state
	logic [N_CH-1:0] arb_req;   // Start requests to the arbiter
	logic [N_CH-1:0] grant;     // One-hot start pulse from the arbiter
	logic            setup;     // APB setup phase
	logic            wr;        // APB write access phase
	logic            rd;        // APB read access phase
	logic            mapped;    // Address hits a register

	// Word address hits a register index inside the decode window
	function automatic logic hit(input logic [31:0] addr, input logic [31:0] idx);
		return (addr[1:0] == 2'b00) && (addr[DEC_BITS+1:2] == idx[DEC_BITS-1:0]);
	endfunction

	// Channel control byte as software sees it
	function automatic logic [7:0] chc_view(input dcc_ch_t c);
		logic [7:0] v;
		v = CHC_RST;
		v[CHC_TC] = c.tc;
		v[CHC_KEEP] = c.keep;
		v[CHC_EN] = c.en;
		// Strobe bits are never stored, so they read as zero
		v[CHC_INIT] = 1'b0;
		v[CHC_STG] = 1'b0;
		return v;
	endfunction

	// Addressing control halfword as software sees it
	function automatic logic [15:0] adc_view(input dcc_adc_t a);
		logic [15:0] v;
		v = ADC_RST;
		v[ADC_SIZE] = a.size;
		v[ADC_SRC_HI:ADC_SRC_LO] = a.src;
		v[ADC_DST_HI:ADC_DST_LO] = a.dst;
		v[ADC_MODE_HI:ADC_MODE_LO] = a.mode;
		return v;
	endfunction

	assign setup = apb_req.psel && !apb_req.penable;
	assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign rd = apb_req.psel && apb_req.penable && !apb_req.pwrite;

	// Address decode for the error answer; read capture decodes each index itself
	always_comb begin
		mapped = hit(apb_req.paddr, IDX_STS) || hit(apb_req.paddr, IDX_PCLR);
		for (int i = 0; i < N_CH; i++) begin
			if (hit(apb_req.paddr, IDX_ADC[i]) || hit(apb_req.paddr, IDX_CHC[i])
				|| hit(apb_req.paddr, IDX_TRG[i])) begin
				mapped = 1'b1;
			end
		end
	end

	// Start requests; standby holds them back but the pending flag stays
	always_comb begin
		for (int i = 0; i < N_CH; i++) begin
			arb_req[i] = !standby && !s_q.ch[i].active && s_q.ch[i].en
				&& ((s_q.ch[i].sw_req && !s_q.ch[i].tc)
				|| (s_q.ch[i].pend && (!s_q.ch[i].tc || s_q.ch[i].keep)));
		end
	end

	// Next-state logic: flag clears first, then sets, so a completion or pending flag set in the same cycle wins
	always_comb begin
		s_d = s_q;
		s_d.abort = '0;

		// Read data is captured in setup so prdata comes from a flop
		if (setup && !apb_req.pwrite) begin
			s_d.rdata = '0;
			for (int i = 0; i < N_CH; i++) begin
				if (hit(apb_req.paddr, IDX_ADC[i]))
					s_d.rdata = {16'h0000, adc_view(s_q.ch[i].adc)};
				if (hit(apb_req.paddr, IDX_CHC[i]))
					s_d.rdata = {24'h000000, chc_view(s_q.ch[i])};
				if (hit(apb_req.paddr, IDX_TRG[i]))
					s_d.rdata = {24'h000000, s_q.ch[i].pend, 1'b0, s_q.ch[i].trig};
				if (hit(apb_req.paddr, IDX_STS))
					s_d.rdata[2*i +: 2] = state_of(s_q.ch[i].tc, s_q.ch[i].en);
			end
		end

		for (int i = 0; i < N_CH; i++) begin
			// Reading the channel control register clears the completion flag
			if (rd && hit(apb_req.paddr, IDX_CHC[i])) begin
				s_d.ch[i].tc = 1'b0;
			end

			// Completion flag countdown; a set here beats the read clear above
			if (s_q.ch[i].tc_wait) begin
				if (s_q.ch[i].tc_cnt <= 3'd1) begin
					s_d.ch[i].tc = 1'b1;
					s_d.ch[i].tc_wait = 1'b0;
				end else begin
					s_d.ch[i].tc_cnt = s_q.ch[i].tc_cnt - 3'd1;
				end
			end

			// Addressing control: whole halfword only, and not while running
			if (wr && hit(apb_req.paddr, IDX_ADC[i]) && apb_req.pstrb[1:0] == 2'b11
				&& !s_q.ch[i].active) begin
				// Unused bits are dropped; software is expected to write them zero
				s_d.ch[i].adc.size = apb_req.pwdata[ADC_SIZE];
				s_d.ch[i].adc.src = apb_req.pwdata[ADC_SRC_HI:ADC_SRC_LO];
				s_d.ch[i].adc.dst = apb_req.pwdata[ADC_DST_HI:ADC_DST_LO];
				s_d.ch[i].adc.mode = apb_req.pwdata[ADC_MODE_HI:ADC_MODE_LO];
			end

			// Channel control write
			if (wr && hit(apb_req.paddr, IDX_CHC[i]) && apb_req.pstrb[0]) begin
				s_d.ch[i].keep = apb_req.pwdata[CHC_KEEP];
				s_d.ch[i].en = apb_req.pwdata[CHC_EN];
				if (apb_req.pwdata[CHC_STG] && s_q.ch[i].en && !s_q.ch[i].tc) begin
					s_d.ch[i].sw_req = 1'b1;
				end
				if (apb_req.pwdata[CHC_INIT]) begin
					// Abort always drops enable, whatever keep-enabled says
					s_d.ch[i].en = 1'b0;
					s_d.ch[i].sw_req = 1'b0;
					if (s_q.ch[i].active) begin
						s_d.ch[i].active = 1'b0;
						s_d.abort[i] = 1'b1;
						// Caught on its last unit with keep-enabled it counts as a normal end
						if (eng_last_cycle[i] && s_q.ch[i].keep) begin
							s_d.ch[i].tc_wait = 1'b1;
							s_d.ch[i].tc_cnt = eng_src_ram[i] ? TC_DLY_RAM_CYC
								: TC_DLY_PIO_CYC;
						end
					end
				end
			end

			// Trigger factor write: source field needs the full byte lane
			if (wr && hit(apb_req.paddr, IDX_TRG[i]) && apb_req.pstrb[0]) begin
				s_d.ch[i].trig = apb_req.pwdata[TRG_SRC_HI:TRG_SRC_LO];
				if (!apb_req.pwdata[TRG_PEND]) begin
					s_d.ch[i].pend = 1'b0;
				end
			end

			// Bit-wise pending clear touches the flag and nothing else
			if (wr && hit(apb_req.paddr, IDX_PCLR) && apb_req.pstrb[0]
				&& apb_req.pwdata[i]) begin
				s_d.ch[i].pend = 1'b0;
			end

			// Grant consumes the software start first, else the pending request
			if (grant[i]) begin
				s_d.ch[i].active = 1'b1;
				if (s_q.ch[i].sw_req)
					s_d.ch[i].sw_req = 1'b0;
				else
					s_d.ch[i].pend = 1'b0;
			end

			// Selected peripheral request sets pending, even in standby
			if (s_q.ch[i].trig != 6'h00 && irq_req[s_q.ch[i].trig]) begin
				s_d.ch[i].pend = 1'b1;
			end

			// Terminal count: enable drops now unless keep-enabled, the flag follows later
			if (eng_done[i] && s_q.ch[i].active) begin
				s_d.ch[i].active = 1'b0;
				if (!s_q.ch[i].keep) begin
					s_d.ch[i].en = 1'b0;
				end
				s_d.ch[i].tc_wait = 1'b1;
				s_d.ch[i].tc_cnt = eng_src_ram[i] ? TC_DLY_RAM_CYC
					: TC_DLY_PIO_CYC;
			end
		end
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Start arbitration
	dcc_prio_arb u_arb (
		.clk   (clk),
		.rst   (rst),
		.req   (arb_req),
		.busy  (eng_busy),
		.grant (grant)
	);

	// APB answer: zero wait states, error on unmapped access
	always_comb begin
		apb_rsp.prdata = s_q.rdata;
		apb_rsp.pready = 1'b1;
		apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;
	end

	// Engine-facing outputs
	always_comb begin
		for (int i = 0; i < N_CH; i++) begin
			ch_cfg[i].halfword = s_q.ch[i].adc.size;
			ch_cfg[i].src = step_of(s_q.ch[i].adc.src);
			ch_cfg[i].dst = step_of(s_q.ch[i].adc.dst);
			ch_cfg[i].mode = dcc_mode_t'(s_q.ch[i].adc.mode);
			ch_state[i] = state_of(s_q.ch[i].tc, s_q.ch[i].en);
		end
	end

	assign xfer_start = grant;
	assign xfer_abort = s_q.abort;

endmodule
`default_nettype wire

// ---- sim/dcc_eng_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Engine stand-in: serves one channel at a time for len+1 cycles
module dcc_eng_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [3:0] start,  // Launch pulse
	input  wire logic [3:0] abort,  // Abort pulse
	input  wire logic [7:0] len,    // Cycles to terminal count
	output logic            busy,   // Engine occupied
	output logic [3:0]      done,   // Terminal count pulse
	output logic [3:0]      last    // Last transfer cycle
);
	logic [7:0] cnt;  // Cycles left
	logic [1:0] ch;   // Channel served
	// Busy follows a launch by one cycle; an abort drops it one cycle later too
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
			done <= 4'h0;
			cnt <= 8'h0;
			ch <= 2'h0;
		end else begin
			done <= 4'h0;
			if (|start) begin
				busy <= 1'b1;
				cnt <= len;
				ch <= {start[3] | start[2], start[3] | start[1]};
			end else if (busy && abort[ch]) begin
				busy <= 1'b0;
			end else if (busy && cnt == 8'h0) begin
				busy <= 1'b0;
				done[ch] <= 1'b1;
			end else if (busy) begin
				cnt <= cnt - 8'h1;
			end
		end
	end
	// Last cycle is the one just before the done pulse
	assign last = (busy && cnt == 8'h0) ? 4'h1 << ch : 4'h0;
endmodule
`default_nettype wire

// ---- sim/dcc_channel_ctrl_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
// Port-level checks of the channel control block
module dcc_channel_ctrl_sva (
	input wire logic                                   clk,
	input wire logic                                   rst,
	input wire dcc_pkg::dcc_apb_req_t                  apb_req,
	input wire dcc_pkg::dcc_apb_rsp_t                  apb_rsp,
	input wire logic                                   standby,
	input wire logic                                   eng_busy,
	input wire logic [dcc_pkg::N_CH-1:0]               eng_done,
	input wire logic [dcc_pkg::N_CH-1:0]               eng_src_ram,
	input wire logic [dcc_pkg::N_CH-1:0]               xfer_start,
	input wire logic [dcc_pkg::N_CH-1:0]               xfer_abort,
	input wire dcc_pkg::dcc_ch_state_t [dcc_pkg::N_CH-1:0] ch_state
);
	import dcc_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Read access to channel 0 control
	wire logic rd0 = apb_req.psel && apb_req.penable && !apb_req.pwrite
		&& apb_req.paddr[13:0] == 14'h0380;
	start_onehot_a: assert property ($onehot0(xfer_start))
		else $error("two channels launched at once");
	start_idle_a: assert property (|xfer_start |-> !$past(eng_busy))
		else $error("launch while engine busy");
	held_standby_a: assert property (standby [*3] |=> xfer_start == '0)
		else $error("launch during standby");
	// Enable falls first, the flag one edge later
	tc_late_a: assert property (
		eng_done[0] && !eng_src_ram[0] && ch_state[0] != ST_ENDED
		|=> ch_state[0] != ST_ENDED ##1 ch_state[0] == ST_ENDED)
		else $error("completion flag timing");
	tc_ram_a: assert property (
		eng_done[0] && eng_src_ram[0] && ch_state[0] != ST_ENDED
		|=> (ch_state[0] != ST_ENDED) [*4] ##1 ch_state[0] == ST_ENDED)
		else $error("RAM source flag delay");
	abort_clears_a: assert property (xfer_abort[0] |-> ch_state[0] != ST_IN_PROGRESS)
		else $error("enable kept after abort");
	start_enabled_a: assert property (xfer_start[0] |-> ch_state[0] != ST_ABORTED)
		else $error("launch while disabled");
	strobe_zero_a: assert property (rd0 |-> apb_rsp.prdata[2:1] == 2'b00)
		else $error("strobe bits read nonzero");
	cover property (eng_done[0] && eng_src_ram[0]);
	cover property (|xfer_abort);
	cover property (xfer_start[0] && ch_state[0] == ST_ENDED);
endmodule
bind dcc_channel_ctrl dcc_channel_ctrl_sva u_sva (.clk, .rst, .apb_req, .apb_rsp, .standby,
	.eng_busy, .eng_done, .eng_src_ram, .xfer_start, .xfer_abort, .ch_state);
`default_nettype wire

// ---- sim/dcc_channel_ctrl_test.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin \
	compares++; \
	if ((a) !== (b)) begin \
		failures++; \
		$display("ERROR t=%0t got %h want %h", $time, (a), (b)); \
	end \
end
// Register-level tests of the channel control block
module dcc_channel_ctrl_test;
	import dcc_pkg::*;
	logic                     clk, rst, standby;  // Clock, reset, standby level
	dcc_apb_req_t             req;                // Bus master drive
	dcc_apb_rsp_t             rsp;                // Slave answer
	logic [N_IRQ-1:0]         irq;                // Peripheral requests
	logic                     busy, err;          // Engine busy, last slave error
	logic [3:0]               done, last, ram;    // Engine status, RAM source
	logic [3:0]               start, abort, s;    // Launch, abort, seen launch
	dcc_cfg_t [N_CH-1:0]      cfg;                // Decoded configuration
	dcc_ch_state_t [N_CH-1:0] st;                 // Channel state
	logic [7:0]               len;                // Engine length
	logic [31:0]              d, w;               // Read data, write word
	int                       failures, compares;
	dcc_step_t stp [4] = '{STEP_INC, STEP_DEC, STEP_FIX, STEP_BAD};
	dcc_mode_t mds [4] = '{MODE_SINGLE, MODE_SSTEP, MODE_BAD, MODE_BLOCK};
	dcc_channel_ctrl u_dut (.clk, .rst, .apb_req(req), .apb_rsp(rsp), .irq_req(irq),
		.standby, .eng_busy(busy), .eng_done(done), .eng_last_cycle(last),
		.eng_src_ram(ram), .xfer_start(start), .xfer_abort(abort), .ch_cfg(cfg),
		.ch_state(st));
	dcc_eng_model u_eng (.clk, .rst, .start, .abort, .len, .busy, .done, .last);
	always #50 clk = ~clk;
	// One APB transfer, held until pready is seen at an edge
	task automatic bus(input logic wr, input logic [31:0] idx, input logic [31:0] wd);
		@(posedge clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: idx << 2, pwdata: wd,
			pstrb: 4'hf};
		@(posedge clk);
		req.penable <= 1'b1;
		do
			@(posedge clk);
		while (rsp.pready !== 1'b1);
		d = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	// Bounded wait for a launch
	task automatic wst(input int n);
		s = '0;
		for (int i = 0; i < n && s == 0; i++) begin
			@(posedge clk);
			s = start;
		end
	endtask
	// Bounded wait for terminal count
	task automatic wdn(input int c);
		int i;
		for (i = 0; i < 300 && done[c] !== 1'b1; i++)
			@(posedge clk);
		// A run that never ends is a failure, not a silent skip
		if (done[c] !== 1'b1) begin
			failures++;
			$display("ERROR t=%0t no terminal count", $time);
		end
	endtask
	// One-cycle peripheral request
	task automatic pulse(input int k);
		@(posedge clk);
		irq[k] <= 1'b1;
		@(posedge clk);
		irq[k] <= 1'b0;
	endtask
	task automatic tdone(input string n);
		$display("test %s done", n);
	endtask
	task automatic final_report;
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Watchdog: far beyond the few hundred cycles the tests need
	initial begin
		#2000000;
		failures++;
		final_report;
	end
	initial begin
		clk = 0;
		rst = 1;
		req = '0;
		irq = '0;
		standby = 0;
		ram = '0;
		len = 8'd3;
		failures = 0;
		compares = 0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (int c = 0; c < N_CH; c++) begin
			bus(0, IDX_CHC[c], 0);
			`CHK(d, {24'h0, CHC_RST})
			bus(0, IDX_TRG[c], 0);
			`CHK(d, {24'h0, TRG_RST})
			bus(0, IDX_ADC[c], 0);
			`CHK(d, {16'h0, ADC_RST})
			`CHK(st[c], ST_ABORTED)
		end
		bus(0, 32'h100, 0);
		`CHK({err, d}, 33'h1_0000_0000)
		bus(1, IDX_TRG[0], 32'h03);
		bus(0, IDX_TRG[0], 0);
		`CHK(d, 32'h03)
		tdone("reset");
		// All step and mode codes; unused bits stay zero
		for (int k = 0; k < 4; k++) begin
			w = {17'h0, 1'(k), 6'h0, 2'(k), 2'(3 - k), 2'(k), 2'b00};
			bus(1, IDX_ADC[0], w);
			bus(0, IDX_ADC[0], 0);
			`CHK(d, w)
			`CHK(cfg[0].halfword, 1'(k))
			`CHK(cfg[0].src, stp[k])
			`CHK(cfg[0].dst, stp[3 - k])
			`CHK(cfg[0].mode, mds[k])
		end
		bus(1, IDX_ADC[0], 0);
		tdone("addressing");
		// Software start refused while disabled, then a full run
		bus(1, IDX_CHC[0], 32'h02);
		wst(20);
		`CHK(s, 4'h0)
		bus(1, IDX_CHC[0], 32'h01);
		bus(1, IDX_CHC[0], 32'h03);
		wst(20);
		`CHK(s, 4'h1)
		wdn(0);
		bus(0, IDX_CHC[0], 0);
		`CHK(d, 32'h80)
		bus(0, IDX_CHC[0], 0);
		`CHK(d, 32'h00)
		tdone("software");
		// Peripheral starts with keep-enabled from RAM, then an abort
		ram <= 4'h1;
		bus(1, IDX_TRG[0], 32'h05);
		bus(1, IDX_CHC[0], 32'h09);
		pulse(5);
		wst(20);
		`CHK(s, 4'h1)
		wdn(0);
		repeat (6) @(posedge clk);
		`CHK(st[0], ST_ENDED)
		bus(1, IDX_CHC[0], 32'h0b);
		wst(20);
		`CHK(s, 4'h0)
		len <= 8'd40;
		pulse(5);
		wst(20);
		`CHK(s, 4'h1)
		`CHK(st[0], ST_ENDED)
		bus(1, IDX_CHC[0], 32'h04);
		repeat (2) @(posedge clk);
		`CHK(busy, 1'b0)
		bus(0, IDX_CHC[0], 0);
		`CHK(d, 32'h80)
		pulse(5);
		bus(0, IDX_TRG[0], 0);
		`CHK(d, 32'h85)
		bus(1, IDX_PCLR, 32'h1);
		bus(0, IDX_TRG[0], 0);
		`CHK(d, 32'h05)
		tdone("keep");
		// Requests held in standby, then served in priority order
		ram <= 4'h0;
		len <= 8'd3;
		for (int c = 2; c < 4; c++) begin
			bus(1, IDX_TRG[c], 32'h07);
			bus(1, IDX_CHC[c], 32'h01);
		end
		standby <= 1'b1;
		pulse(7);
		wst(10);
		`CHK(s, 4'h0)
		bus(0, IDX_TRG[3], 0);
		`CHK(d, 32'h87)
		standby <= 1'b0;
		wst(20);
		`CHK(s, 4'h4)
		wst(40);
		`CHK(s, 4'h8)
		tdone("priority");
		final_report;
	end
endmodule
`default_nettype wire
